// File: phb_pkg.sv
package phb_pkg;

    // Pin, port and field widths.
    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 16;
    localparam int NUM_RDY  = 4;
    localparam int NUM_EVT  = 5;
    localparam int NUM_SOCK = 8;
    localparam int SIZE_W   = 16;
    localparam int SOCK_W   = 3;
    localparam int WDF_W    = 3;

    // Device register byte addresses.
    localparam logic [ADDR_W-1:0] MODE_ADDR    = 10'h000;
    localparam logic [ADDR_W-1:0] IRQ_ST_ADDR  = 10'h002;
    localparam logic [ADDR_W-1:0] IRQ_MK_ADDR  = 10'h004;
    localparam logic [ADDR_W-1:0] RDY_CFG_BASE = 10'h020;
    localparam logic [ADDR_W-1:0] RDY_DEP_BASE = 10'h030;
    localparam int                RDY_STEP     = 2;

    // Field positions.
    localparam int MODE_BW_BIT  = 15;
    localparam int MODE_WDF_LSB = 11;
    localparam int CFG_EN_BIT   = 7;
    localparam int CFG_POL_BIT  = 6;
    localparam int CFG_TX_BIT   = 5;
    localparam int CFG_SOCK_LSB = 0;

    // Reset values.
    localparam logic [WDF_W-1:0]   WDF_RST  = 3'h0;
    localparam logic [NUM_EVT-1:0] MASK_RST = 5'h00;
    localparam logic [7:0]         CFG_RST  = 8'h00;
    localparam logic [SIZE_W-1:0]  DEP_RST  = 16'h0000;

    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_LOW_NS    = 2000;
    localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_WAIT_MS   = 10;
    localparam int PLL_WAIT_CYC  = (PLL_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC    = 16;

    // Controller registers on Avalon-MM, word indices.
    localparam int                AV_ADDR_W   = 3;
    localparam logic [AV_ADDR_W-1:0] HREG_ADDR   = 3'h0;
    localparam logic [AV_ADDR_W-1:0] HREG_WDATA  = 3'h1;
    localparam logic [AV_ADDR_W-1:0] HREG_CTRL   = 3'h2;
    localparam logic [AV_ADDR_W-1:0] HREG_STATUS = 3'h3;
    localparam logic [AV_ADDR_W-1:0] HREG_RDATA  = 3'h4;
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_GO_BIT   = 1;
    localparam int CTRL_RST_BIT  = 2;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_INT_BIT    = 1;
    localparam int ST_BUFFER_READY_PINS_LSB   = 4;

endpackage

// File: phb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface phb_if;
    import phb_pkg::*;

    logic                 hw_rst_b;
    logic                 cs_b;
    logic                 rd_b;
    logic                 wr_b;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    host_dq_o;
    logic                 host_dq_oe_b;
    logic [DATA_W-1:0]    dev_dq_o;
    logic [1:0]           dev_dq_oe_b;
    logic [DATA_W-1:0]    dq;
    logic                 int_b;
    logic [NUM_RDY-1:0]   buffer_ready_pins;

    // Floating lanes read as ones, as a pulled-up bus would.
    assign dq[7:0]  = !dev_dq_oe_b[0] ? dev_dq_o[7:0]  :
                      !host_dq_oe_b   ? host_dq_o[7:0] : 8'hff;
    assign dq[15:8] = !dev_dq_oe_b[1] ? dev_dq_o[15:8] :
                      !host_dq_oe_b   ? host_dq_o[15:8] : 8'hff;

    modport dev (
        input  hw_rst_b, cs_b, rd_b, wr_b, addr, dq,
        output dev_dq_o, dev_dq_oe_b, int_b, buffer_ready_pins
    );

    modport host (
        output hw_rst_b, cs_b, rd_b, wr_b, addr, host_dq_o, host_dq_oe_b,
        input  dq, int_b, buffer_ready_pins
    );
endinterface
`default_nettype wire

// File: phb_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module phb_pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         sys_clk_in,
    input  wire logic         rst_b_in,
    // Pins and filtered levels.
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } phb_sync_t;

    phb_sync_t q;
    phb_sync_t d;

    // The first stage feeds only the second; a bit counts once stages two and three agree.
    always_comb begin
        d     = q;
        d.s1  = pin_in;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.lvl = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign level_out = q.lvl;
endmodule
`default_nettype wire

// File: phb_dev.sv
// Summary of operation
// - Host holds reset low at least 2 us.
// - Host waits 10 ms after reset release.
// - System itself must generate the reset pulse.
// - Strap high selects 16-bit, low 8-bit.
// - Strap captured into mode bit 15.
// - Strap changes ignored after reset ends.
// - 16-bit mode ignores address line zero.
// - 8-bit mode floats upper eight data lines.
// - Chip select high floats all data lines.
// - Write strobe stores data to addressed register; ones written to interrupt status clear its bits.
// - Write data fetched after programmed delay.
// - Read strobe drives addressed register onto bus.
// - Interrupt output goes low on unmasked events.
// - Each ready pin picks socket, type, depth.
// - Ready pin asserts when size reaches depth.
`timescale 1ns/1ps
`default_nettype none
module phb_dev (
    // Clock and reset.
    input  wire logic                                        sys_clk_in,
    input  wire logic                                        rst_b_in,
    // Board strap and core events.
    input  wire logic                                        bus_width_strap_in,
    input  wire logic [phb_pkg::NUM_EVT-1:0]                 irq_event_in,
    // Socket buffer levels.
    input  wire logic [phb_pkg::NUM_SOCK-1:0][phb_pkg::SIZE_W-1:0] tx_free_in,
    input  wire logic [phb_pkg::NUM_SOCK-1:0][phb_pkg::SIZE_W-1:0] rx_size_in,
    // Status towards the core.
    output logic                                             bus_width_flag_out,
    output logic                                             irq_pending_out,
    // Host port pins.
    phb_if.dev                                               bus
);
    import phb_pkg::*;

    typedef enum logic [1:0] {
        DS_IDLE,
        DS_FETCH,
        DS_DONE
    } phb_dev_st_t;

    typedef struct packed {
        phb_dev_st_t                    st;
        logic [WDF_W-1:0]               cnt;
        logic [ADDR_W-1:0]              waddr;
        logic                           bw;
        logic [WDF_W-1:0]               write_fetch_timing;
        logic [NUM_EVT-1:0]             irq_st;
        logic [NUM_EVT-1:0]             irq_mk;
        logic [NUM_RDY-1:0][7:0]        cfg;
        logic [NUM_RDY-1:0][SIZE_W-1:0] dep;
        logic [DATA_W-1:0]              dq_o;
        logic [1:0]                     oe_b;
        logic                           int_b;
        logic [NUM_RDY-1:0]             buffer_ready_pins;
        logic                           pend;
    } phb_dev_t;

    localparam phb_dev_t DEV_RST = '{
        st:     DS_IDLE,
        cnt:    '0,
        waddr:  '0,
        bw:     1'h0,
        write_fetch_timing:    WDF_RST,
        irq_st: '0,
        irq_mk: MASK_RST,
        cfg:    {NUM_RDY{CFG_RST}},
        dep:    {NUM_RDY{DEP_RST}},
        dq_o:   '0,
        oe_b:   2'h3,
        int_b:  1'h1,
        buffer_ready_pins:   {NUM_RDY{1'h1}},
        pend:   1'h0
    };

    localparam int SYNC_W = 5 + ADDR_W + DATA_W;

    phb_dev_t q;
    phb_dev_t d;

    logic                           hw_rst_b_s;
    logic                           cs_b_s;
    logic                           rd_b_s;
    logic                           wr_b_s;
    logic                           strap_s;
    logic [ADDR_W-1:0]              addr_s;
    logic [DATA_W-1:0]              dq_s;
    logic [NUM_RDY-1:0][SIZE_W-1:0] rdy_size;

    // Every host pin is asynchronous to this clock, so all of them are filtered.
    phb_pin_sync #(
        .W       (SYNC_W),
        .RST_VAL (31'h38000000)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     ({bus.hw_rst_b, bus.cs_b, bus.rd_b, bus.wr_b,
                      bus_width_strap_in, bus.addr, bus.dq}),
        .level_out  ({hw_rst_b_s, cs_b_s, rd_b_s, wr_b_s, strap_s, addr_s, dq_s})
    );

    // Each ready pin watches one socket's transmit or receive level.
    genvar g;
    for (g = 0; g < NUM_RDY; g++) begin : g_rdy
        assign rdy_size[g] = q.cfg[g][CFG_TX_BIT]
                           ? tx_free_in[q.cfg[g][CFG_SOCK_LSB +: SOCK_W]]
                           : rx_size_in[q.cfg[g][CFG_SOCK_LSB +: SOCK_W]];
    end

    function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a,
                                                  input phb_dev_t          s);
        logic [DATA_W-1:0] r;
        r = '0;
        if (a == MODE_ADDR) begin
            r[MODE_BW_BIT] = s.bw;
            r[MODE_WDF_LSB +: WDF_W] = s.write_fetch_timing;
        end
        if (a == IRQ_ST_ADDR) begin
            r[NUM_EVT-1:0] = s.irq_st;
        end
        if (a == IRQ_MK_ADDR) begin
            r[NUM_EVT-1:0] = s.irq_mk;
        end
        for (int i = 0; i < NUM_RDY; i++) begin
            if (a == ADDR_W'(RDY_CFG_BASE + RDY_STEP * i)) begin
                r[7:0] = s.cfg[i];
            end
            if (a == ADDR_W'(RDY_DEP_BASE + RDY_STEP * i)) begin
                r = s.dep[i];
            end
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [1:0]        be);
        return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    always_comb begin
        logic              wr_act;
        logic              rd_act;
        logic              commit;
        logic [ADDR_W-1:0] wa;
        logic [ADDR_W-1:0] ra;
        logic [1:0]        be;
        logic [DATA_W-1:0] wd;
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] rw;
        logic [NUM_EVT-1:0] clr;
        d      = q;
        wr_act = !cs_b_s && !wr_b_s;
        rd_act = !cs_b_s && !rd_b_s && wr_b_s;
        commit = 1'h0;
        clr    = '0;
        // Registers are word wide; the low address bit only picks a byte lane.
        wa     = {q.waddr[ADDR_W-1:1], 1'h0};
        ra     = {addr_s[ADDR_W-1:1], 1'h0};
        be     = q.bw ? 2'h3 : (q.waddr[0] ? 2'h1 : 2'h2);
        wd     = q.bw ? dq_s : {dq_s[7:0], dq_s[7:0]};
        m      = merge(rd_word(wa, q), wd, be);

        unique case (q.st)
            DS_IDLE: begin
                if (wr_act) begin
                    d.waddr = addr_s;
                    d.cnt   = '0;
                    d.st    = DS_FETCH;
                end
            end
            DS_FETCH: begin
                // A strobe shorter than the fetch delay still commits, at its release.
                if (!wr_act || q.cnt == q.write_fetch_timing) begin
                    commit = 1'h1;
                    d.st   = wr_act ? DS_DONE : DS_IDLE;
                end else begin
                    d.cnt = q.cnt + 3'h1;
                end
            end
            DS_DONE: begin
                if (!wr_act) begin
                    d.st = DS_IDLE;
                end
            end
        endcase

        if (commit) begin
            if (wa == MODE_ADDR) begin
                d.write_fetch_timing = m[MODE_WDF_LSB +: WDF_W];
            end
            if (wa == IRQ_ST_ADDR && be[0]) begin
                clr = wd[NUM_EVT-1:0];
            end
            if (wa == IRQ_MK_ADDR) begin
                d.irq_mk = m[NUM_EVT-1:0];
            end
            for (int i = 0; i < NUM_RDY; i++) begin
                if (wa == ADDR_W'(RDY_CFG_BASE + RDY_STEP * i)) begin
                    d.cfg[i] = m[7:0];
                end
                if (wa == ADDR_W'(RDY_DEP_BASE + RDY_STEP * i)) begin
                    d.dep[i] = m;
                end
            end
        end

        // A new event outranks a clear written in the same cycle.
        d.irq_st = (q.irq_st & ~clr) | irq_event_in;
        d.int_b  = ~|(q.irq_st & q.irq_mk);
        d.pend   = ~d.int_b;

        rw = rd_word(ra, q);
        if (rd_act) begin
            d.dq_o = q.bw ? rw : {8'h00, addr_s[0] ? rw[7:0] : rw[15:8]};
            d.oe_b = q.bw ? 2'h0 : 2'h2;
        end else begin
            d.oe_b = 2'h3;
        end

        for (int i = 0; i < NUM_RDY; i++) begin
            d.buffer_ready_pins[i] = (q.cfg[i][CFG_EN_BIT] && rdy_size[i] >= q.dep[i])
                      ? q.cfg[i][CFG_POL_BIT] : !q.cfg[i][CFG_POL_BIT];
        end

        // While the reset pin is low the port is idle and the strap is followed.
        if (!hw_rst_b_s) begin
            d    = DEV_RST;
            d.bw = strap_s;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.dev_dq_o    = q.dq_o;
    assign bus.dev_dq_oe_b = q.oe_b;
    assign bus.int_b       = q.int_b;
    assign bus.buffer_ready_pins        = q.buffer_ready_pins;
    assign bus_width_flag_out = q.bw;
    assign irq_pending_out    = q.pend;
endmodule
`default_nettype wire

// File: phb_host.sv
`timescale 1ns/1ps
`default_nettype none
module phb_host #(
    parameter int PLL_WAIT_CYC = phb_pkg::PLL_WAIT_CYC,
    parameter int ACCESS_CYC   = phb_pkg::ACCESS_CYC
) (
    // Clock and reset.
    input  wire logic                           sys_clk_in,
    input  wire logic                           rst_b_in,
    // Avalon-MM slave.
    input  wire logic [phb_pkg::AV_ADDR_W-1:0]  avs_address_in,
    input  wire logic                           avs_read_in,
    input  wire logic                           avs_write_in,
    input  wire logic [31:0]                    avs_writedata_in,
    output logic      [31:0]                    avs_readdata_out,
    output logic                                avs_waitrequest_out,
    // Device pins.
    phb_if.host                                 bus
);
    import phb_pkg::*;

    typedef enum logic [2:0] {
        HS_RST_LOW,
        HS_PLL_WAIT,
        HS_IDLE,
        HS_SETUP,
        HS_STROBE,
        HS_HOLD
    } phb_host_st_t;

    typedef struct packed {
        phb_host_st_t      st;
        logic [31:0]       cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              is_read;
        logic              rst_b;
        logic              cs_b;
        logic              rd_b;
        logic              wr_b;
        logic              oe_b;
        logic              wait_r;
        logic [31:0]       av_rdata;
    } phb_host_t;

    localparam phb_host_t HOST_RST = '{
        st:       HS_RST_LOW,
        rst_b:    1'h0,
        cs_b:     1'h1,
        rd_b:     1'h1,
        wr_b:     1'h1,
        oe_b:     1'h1,
        wait_r:   1'h1,
        default:  '0
    };

    phb_host_t q;
    phb_host_t d;

    logic [DATA_W-1:0]  dq_s;
    logic               int_b_s;
    logic [NUM_RDY-1:0] buffer_ready_pins_s;

    phb_pin_sync #(
        .W       (DATA_W + 1 + NUM_RDY),
        .RST_VAL (21'h000010)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     ({bus.dq, bus.int_b, bus.buffer_ready_pins}),
        .level_out  ({dq_s, int_b_s, buffer_ready_pins_s})
    );

    always_comb begin
        logic [31:0] rd_v;
        d    = q;
        rd_v = '0;
        unique case (avs_address_in)
            HREG_ADDR:   rd_v[ADDR_W-1:0] = q.addr;
            HREG_WDATA:  rd_v[DATA_W-1:0] = q.wdata;
            HREG_STATUS: begin
                rd_v[ST_BUSY_BIT] = q.st != HS_IDLE;
                rd_v[ST_INT_BIT]  = !int_b_s;
                rd_v[ST_BUFFER_READY_PINS_LSB +: NUM_RDY] = buffer_ready_pins_s;
            end
            HREG_RDATA:  rd_v[DATA_W-1:0] = q.rdata;
            default:     rd_v = '0;
        endcase

        // One wait cycle per access; the answer stands while waitrequest is low.
        d.wait_r = 1'h1;
        if ((avs_read_in || avs_write_in) && q.wait_r) begin
            d.wait_r = 1'h0;
            if (avs_read_in) begin
                d.av_rdata = rd_v;
            end
        end

        unique case (q.st)
            HS_RST_LOW: begin
                d.cnt = q.cnt + 32'h1;
                if (q.cnt == 32'(RST_LOW_CYC - 1)) begin
                    d.cnt   = '0;
                    d.rst_b = 1'h1;
                    d.st    = HS_PLL_WAIT;
                end
            end
            HS_PLL_WAIT: begin
                d.cnt = q.cnt + 32'h1;
                if (q.cnt == 32'(PLL_WAIT_CYC - 1)) begin
                    d.st = HS_IDLE;
                end
            end
            HS_IDLE: begin
                // A write lands only at the edge where the master sees waitrequest low.
                if (avs_write_in && !q.wait_r) begin
                    if (avs_address_in == HREG_ADDR) begin
                        d.addr = avs_writedata_in[ADDR_W-1:0];
                    end
                    if (avs_address_in == HREG_WDATA) begin
                        d.wdata = avs_writedata_in[DATA_W-1:0];
                    end
                    if (avs_address_in == HREG_CTRL) begin
                        if (avs_writedata_in[CTRL_RST_BIT]) begin
                            d.cnt   = '0;
                            d.rst_b = 1'h0;
                            d.st    = HS_RST_LOW;
                        end else if (avs_writedata_in[CTRL_GO_BIT]) begin
                            d.is_read = avs_writedata_in[CTRL_READ_BIT];
                            d.cs_b    = 1'h0;
                            d.oe_b    = avs_writedata_in[CTRL_READ_BIT];
                            d.st      = HS_SETUP;
                        end
                    end
                end
            end
            HS_SETUP: begin
                d.rd_b = !q.is_read;
                d.wr_b = q.is_read;
                d.cnt  = '0;
                d.st   = HS_STROBE;
            end
            HS_STROBE: begin
                d.cnt = q.cnt + 32'h1;
                if (q.cnt == 32'(ACCESS_CYC - 1)) begin
                    d.rdata = dq_s;
                    d.rd_b  = 1'h1;
                    d.wr_b  = 1'h1;
                    d.st    = HS_HOLD;
                end
            end
            HS_HOLD: begin
                d.cs_b = 1'h1;
                d.oe_b = 1'h1;
                d.st   = HS_IDLE;
            end
            default: d.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.hw_rst_b     = q.rst_b;
    assign bus.cs_b         = q.cs_b;
    assign bus.rd_b         = q.rd_b;
    assign bus.wr_b         = q.wr_b;
    assign bus.addr         = q.addr;
    assign bus.host_dq_o    = q.wdata;
    assign bus.host_dq_oe_b = q.oe_b;
    assign avs_readdata_out    = q.av_rdata;
    assign avs_waitrequest_out = q.wait_r;
endmodule
`default_nettype wire

// File: phb_host_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: phb_sva.sv
`timescale 1ns/1ps
`default_nettype none
module phb_sva (
    // Clock, reset and latched width.
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       bus_width_flag_out,
    // Pin link.
    input  wire logic       hw_rst_b,
    input  wire logic       cs_b,
    input  wire logic       rd_b,
    input  wire logic       wr_b,
    input  wire logic       host_dq_oe_b,
    input  wire logic [1:0] dev_dq_oe_b,
    input  wire logic       int_b
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    // The filters give the device a few cycles of lag, so eight settles any edge.
    property p_cs_float; cs_b [*8] |-> dev_dq_oe_b == 2'h3; endproperty
    a_cs_float: assert property (p_cs_float) else $error("data driven while deselected");
    property p_narrow; !bus_width_flag_out |-> dev_dq_oe_b[1]; endproperty
    a_narrow: assert property (p_narrow) else $error("upper lane driven in narrow mode");
    property p_frozen; hw_rst_b [*8] |-> $stable(bus_width_flag_out); endproperty
    a_frozen: assert property (p_frozen) else $error("width flag moved after reset");
    property p_int_hold; $fell(int_b) ##1 (wr_b && hw_rst_b) [*8] |-> !int_b; endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt released without a write");
    property p_excl; !(!rd_b && !wr_b); endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    property p_sel; (!rd_b || !wr_b) |-> !cs_b; endproperty
    a_sel: assert property (p_sel) else $error("strobe without chip select");
    property p_rd_drive; (!cs_b && !rd_b) [*8] |-> !dev_dq_oe_b[0]; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
    property p_host_off; !rd_b |-> host_dq_oe_b; endproperty
    a_host_off: assert property (p_host_off) else $error("host drives during read");
    property p_wr_drive; !wr_b |-> !host_dq_oe_b && dev_dq_oe_b == 2'h3; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not owned by host");
    property p_idle; rd_b [*8] |-> dev_dq_oe_b == 2'h3; endproperty
    a_idle: assert property (p_idle) else $error("device drives without a read");

    c_read: cover property (!cs_b && !rd_b ##1 rd_b);
    c_write: cover property (!cs_b && !wr_b ##1 wr_b);
    c_int: cover property ($fell(int_b));
    c_narrow: cover property (!bus_width_flag_out && !rd_b);
endmodule
`default_nettype wire

// File: parallel_host_bus_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_host_bus_interface_bench;
    import phb_pkg::*;
    logic                            sys_clk_in, rst_b_in, strap, bw_flag, irq_pend;
    logic [NUM_EVT-1:0]              irq_ev;
    logic [NUM_SOCK-1:0][SIZE_W-1:0] tx_free, rx_size;
    logic [AV_ADDR_W-1:0]            av_addr;
    logic                            av_rd, av_wr, av_wait;
    logic [31:0]                     av_wdata, av_q, st;
    logic [15:0]                     rd_val;
    int                              fail_count, compares;
    int                              cycles = 0;

    phb_if bus_if ();
    phb_dev u_phb_dev (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .bus_width_strap_in(strap), .irq_event_in(irq_ev), .tx_free_in(tx_free),
        .rx_size_in(rx_size), .bus_width_flag_out(bw_flag), .irq_pending_out(irq_pend),
        .bus(bus_if));
    // A short settle wait keeps the run brief; the host counts it the same way.
    phb_host #(.PLL_WAIT_CYC(50)) u_phb_host (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
        .avs_writedata_in(av_wdata), .avs_readdata_out(av_q),
        .avs_waitrequest_out(av_wait), .bus(bus_if));
    phb_sva u_phb_sva (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .bus_width_flag_out(bw_flag), .hw_rst_b(bus_if.hw_rst_b), .cs_b(bus_if.cs_b),
        .rd_b(bus_if.rd_b), .wr_b(bus_if.wr_b), .host_dq_oe_b(bus_if.host_dq_oe_b),
        .dev_dq_oe_b(bus_if.dev_dq_oe_b), .int_b(bus_if.int_b));

    initial begin
        sys_clk_in = 1'h0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task av_xfer(input logic rd, input logic [AV_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        av_addr <= a;
        av_rd <= rd;
        av_wr <= !rd;
        av_wdata <= d;
        do @(posedge sys_clk_in); while (av_wait !== 1'h0);
        st = av_q;
        av_rd <= 1'h0;
        av_wr <= 1'h0;
    endtask

    task wait_idle;
        do av_xfer(1'h1, HREG_STATUS, 32'h0); while (st[ST_BUSY_BIT] !== 1'h0);
    endtask

    task dev_acc(input logic rd, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        av_xfer(1'h0, HREG_ADDR, {22'h0, a});
        av_xfer(1'h0, HREG_WDATA, {16'h0, d});
        av_xfer(1'h0, HREG_CTRL, {30'h0, 1'h1, rd});
        wait_idle;
        av_xfer(1'h1, HREG_RDATA, 32'h0);
        rd_val = st[15:0];
    endtask

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            results;
        end
    end

    initial begin
        {rst_b_in, irq_ev, tx_free, rx_size, av_addr, av_rd, av_wr, av_wdata} = '0;
        strap = 1'h1;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge sys_clk_in);
        rst_b_in <= 1'h1;
        wait_idle;
        check("width flag", 32'(bw_flag), 32'h1);
        strap <= 1'h0;
        repeat (20) @(posedge sys_clk_in);
        check("width held", 32'(bw_flag), 32'h1);
        dev_acc(1'h1, MODE_ADDR, 16'h0);
        check("mode", 32'(rd_val), 32'h8000);
        dev_acc(1'h0, 10'h001, 16'h2800);
        dev_acc(1'h1, MODE_ADDR, 16'h0);
        check("mode fetch", 32'(rd_val), 32'ha800);
        av_xfer(1'h1, 3'h7, 32'h0);
        check("unmapped", st, 32'h0);
        dev_acc(1'h0, IRQ_MK_ADDR, 16'h001f);
        @(posedge sys_clk_in) irq_ev <= 5'h04;
        @(posedge sys_clk_in) irq_ev <= 5'h00;
        dev_acc(1'h1, IRQ_ST_ADDR, 16'h0);
        check("irq status", 32'(rd_val), 32'h0004);
        check("irq pending", 32'(irq_pend), 32'h1);
        check("int pin", 32'(bus_if.int_b), 32'h0);
        dev_acc(1'h0, IRQ_ST_ADDR, 16'h0004);
        av_xfer(1'h1, HREG_STATUS, 32'h0);
        check("int cleared", 32'(st[ST_INT_BIT]), 32'h0);
        dev_acc(1'h0, RDY_CFG_BASE, 16'h00a3);
        dev_acc(1'h0, RDY_CFG_BASE + 10'h2, 16'h0085);
        dev_acc(1'h0, RDY_DEP_BASE, 16'h0100);
        dev_acc(1'h0, RDY_DEP_BASE + 10'h2, 16'h0010);
        tx_free[3] <= 16'h00ff;
        rx_size[5] <= 16'h0010;
        repeat (8) @(posedge sys_clk_in);
        check("ready below", 32'(bus_if.buffer_ready_pins), 32'hd);
        tx_free[3] <= 16'h0100;
        repeat (8) @(posedge sys_clk_in);
        check("ready equal", 32'(bus_if.buffer_ready_pins), 32'hc);
        av_xfer(1'h1, HREG_STATUS, 32'h0);
        check("ready status", 32'(st[ST_BUFFER_READY_PINS_LSB +: NUM_RDY]), 32'hc);
        av_xfer(1'h0, HREG_CTRL, 32'h4);
        wait_idle;
        check("narrow flag", 32'(bw_flag), 32'h0);
        dev_acc(1'h0, MODE_ADDR, 16'h0018);
        dev_acc(1'h1, MODE_ADDR, 16'h0);
        // The upper lane floats in narrow mode, so the pulled-up bus reads it as ones.
        check("narrow high", 32'(rd_val), 32'hff18);
        dev_acc(1'h1, 10'h001, 16'h0);
        check("narrow low", 32'(rd_val), 32'hff00);
        results;
    end
endmodule
`default_nettype wire
